/* File: core/caf_datapath.sv */
// execution datapath: registers, temporaries, mul/div/shift, status word
// assumes a microcode sequencer on step_* and one AHB-Lite master
`timescale 1ns/10ps
`default_nettype none
module caf_datapath
  import caf_pkg::*;
(
  input wire logic sys_clk_in, // core clock
  input wire logic rst_n_in, // async reset, active low
  input wire logic ce_in, // clock enable, freezes all state
  input wire logic hsel_in, // ahb slave select
  input wire logic [31:0] haddr_in, // ahb address
  input wire logic [1:0] htrans_in, // ahb transfer type
  input wire logic hwrite_in, // ahb write
  input wire logic [2:0] hsize_in, // ahb size
  input wire logic [31:0] hwdata_in, // ahb write data
  input wire logic hready_in, // ahb bus ready
  output logic [31:0] hrdata_out, // ahb read data
  output logic hreadyout_out, // ahb slave ready
  output logic hresp_out, // ahb response, always okay
  input wire logic step_valid_in, // micro-step present
  input wire caf_op_t step_op_in, // alu / mul / div / shift op
  input wire caf_shift_t step_shift_in, // shift kind
  input wire caf_ctl_t step_ctl_in, // status / control action
  input wire logic step_word_in, // 1 word, 0 byte
  input wire logic step_use_cl_in, // shift count from count low byte
  input wire logic [3:0] step_a_sel_in, // operand a slot
  input wire logic step_a_hi_in, // operand a high byte
  input wire logic [3:0] step_b_sel_in, // operand b slot
  input wire logic step_b_hi_in, // operand b high byte
  input wire logic [15:0] step_imm_in, // immediate / popped status
  input wire logic [3:0] step_dst_sel_in, // destination slot
  input wire logic step_dst_hi_in, // destination high byte
  input wire logic step_write_in, // write result to destination
  output logic [15:0] status_word_out, // status word image
  output logic [15:0] src_addr_out, // source index
  output logic [15:0] dst_addr_out, // destination index
  output logic [15:0] io_data_out, // accumulator for io
  output logic count_zero_out, // loop count reached zero
  output logic native_mode_out, // native mode flag
  output logic dir_flag_out // block direction, 1 = down
);
  logic [15:0] regs_q [NREG];
  logic [15:0] regs_d [NREG];
  logic [15:0] psw_q;
  logic [15:0] psw_d;
  logic md_we_q;
  logic md_we_d;
  caf_phase_t ph_q;
  caf_phase_t ph_d;
  logic [3:0] ba_idx_q;
  logic ba_hit_q;
  logic [15:0] wmask_q;
  logic [31:0] hrdata_q;
  logic [15:0] wb;
  caf_alu_if alu_bus();

  caf_alu u_alu (
    .bus(alu_bus)
  );

  // operand fetch: whole word or one byte of a slot, or the immediate
  function automatic logic [15:0] rd_opnd(input logic [3:0] s, input logic h, input logic w);
    logic [15:0] v;
    v = (s == R_IMM) ? step_imm_in : ((s < NREG_SEL) ? regs_q[s] : 16'h0000);
    rd_opnd = (w || s == R_IMM) ? v : {8'h00, h ? v[15:8] : v[7:0]};
  endfunction : rd_opnd

  // widen a byte operand, signed or not
  function automatic logic [15:0] ext16(input logic [15:0] v, input logic w, input logic s);
    ext16 = w ? v : {s ? {8{v[7]}} : 8'h00, v[7:0]};
  endfunction : ext16

  // right shift that enters at bit 7 for bytes
  function automatic logic [15:0] rsh(input logic [15:0] v, input logic b, input logic w);
    rsh = w ? {b, v[15:1]} : {8'h00, b, v[7:1]};
  endfunction : rsh

  // n single-bit steps; carry ends as the last bit moved out
  function automatic logic [16:0] shift_n(input logic [15:0] v, input logic c,
    input caf_shift_t k, input logic w, input logic [4:0] n);
    logic [15:0] r;
    logic cc;
    logic msb;
    logic lsb;
    r = v;
    cc = c;
    for (int i = 0; i < 31; i++)
    begin
      if (5'(i) < n)
      begin
        msb = w ? r[15] : r[7];
        lsb = r[0];
        case (k)
          SH_ROL: begin r = {r[14:0], msb}; cc = msb; end
          SH_ROR: begin r = rsh(r, lsb, w); cc = lsb; end
          SH_RCL: begin r = {r[14:0], cc}; cc = msb; end
          SH_RCR: begin r = rsh(r, cc, w); cc = lsb; end
          SH_SHL: begin r = {r[14:0], 1'b0}; cc = msb; end
          SH_SHR: begin r = rsh(r, 1'b0, w); cc = lsb; end
          SH_SAR: begin r = rsh(r, msb, w); cc = lsb; end
          default: r = r;
        endcase
      end
    end
    shift_n = {cc, r};
  endfunction : shift_n

  // step decode
  wire logic go = ce_in && step_valid_in;
  wire logic [15:0] opa = rd_opnd(step_a_sel_in, step_a_hi_in, step_word_in);
  wire logic [15:0] opb = rd_opnd(step_b_sel_in, step_b_hi_in, step_word_in);
  wire logic is_mul = (step_op_in == OP_MULU) || (step_op_in == OP_MULS)
    || (step_op_in == OP_MULI);
  wire logic is_div = (step_op_in == OP_DIVU) || (step_op_in == OP_DIVS);
  wire logic is_sh = (step_op_in == OP_SHIFT);
  wire logic dst_ok = step_dst_sel_in < NREG_SEL;

  assign alu_bus.op = step_op_in;
  assign alu_bus.word = step_word_in;
  assign alu_bus.a = opa;
  assign alu_bus.b = opb;
  assign alu_bus.cy_in = psw_q[PSW_CY];

  // multiplier; signed forms sign-extend both factors to 32 bits
  wire logic mul_sgn = (step_op_in != OP_MULU);
  wire logic mul_wd = step_word_in || (step_op_in == OP_MULI);
  wire logic [15:0] mx = ext16(opa, mul_wd, mul_sgn);
  wire logic [15:0] my = ext16(opb, mul_wd, mul_sgn);
  wire logic signed [31:0] smul = $signed({{16{mx[15]}}, mx}) * $signed({{16{my[15]}}, my});
  wire logic [31:0] umul = {16'h0000, mx} * {16'h0000, my};
  wire logic [31:0] mul_w = mul_sgn ? smul : umul;
  wire logic [15:0] mul_ext = mul_sgn ? {16{mul_w[15]}} : 16'h0000;
  wire logic mul_fit = mul_wd ? (mul_w[31:16] == mul_ext)
    : (mul_w[15:8] == (mul_sgn ? {8{mul_w[7]}} : 8'h00));

  // divider; a zero divisor gives all-ones quotient, the sequencer traps it
  wire logic div_sgn = (step_op_in == OP_DIVS);
  wire logic [15:0] acc = regs_q[R_ACC];
  wire logic [31:0] dvd = step_word_in ? {regs_q[R_DATA], acc}
    : {div_sgn ? {16{acc[15]}} : 16'h0000, acc};
  wire logic [15:0] dy = ext16(opb, step_word_in, div_sgn);
  wire logic dz = (dy == 16'h0000);
  wire logic [31:0] dvs = dz ? 32'h0000_0001 : {div_sgn ? {16{dy[15]}} : 16'h0000, dy};
  wire logic signed [31:0] squo = $signed(dvd) / $signed(dvs);
  wire logic signed [31:0] srem = $signed(dvd) % $signed(dvs);
  wire logic [31:0] quo = dz ? 32'hFFFF_FFFF : (div_sgn ? squo : dvd / dvs);
  wire logic [31:0] rem = dz ? dvd : (div_sgn ? srem : dvd % dvs);

  // shifter works on operand a and writes the low temporary; count from count low byte or one
  wire logic [4:0] sh_cnt = step_use_cl_in ? regs_q[R_CNT][4:0] : 5'h01;
  wire logic [16:0] sh_w = shift_n(opa, psw_q[PSW_CY], step_shift_in, step_word_in, sh_cnt);
  wire logic [15:0] sh_r = sh_w[15:0];
  wire logic sh_msb = step_word_in ? sh_r[15] : sh_r[7];
  wire logic sh_nxt = step_word_in ? sh_r[14] : sh_r[6];
  wire logic sh_left = (step_shift_in == SH_ROL) || (step_shift_in == SH_RCL)
    || (step_shift_in == SH_SHL);
  wire logic [15:0] step_str = step_word_in ? TWO16 : ONE16;

  // writeback value for the destination slot
  always_comb
  begin
    if (is_mul)
      wb = mul_w[15:0];
    else if (is_sh)
      wb = sh_r;
    else
      wb = alu_bus.res;
  end

  // ahb decode
  wire logic ahb_go = hready_in && hsel_in && htrans_in[1];
  wire logic a_hit = (haddr_in[31:6] == 26'h000_0000) && (haddr_in[5:2] <= R_STATUS);
  wire logic [15:0] a_mask = (hsize_in == 3'h0) ? (haddr_in[1:0] == 2'h0 ? WM_LO
    : haddr_in[1:0] == 2'h1 ? WM_HI : 16'h0000)
    : (hsize_in == 3'h1) ? (haddr_in[1] ? 16'h0000 : WM_ALL) : WM_ALL;
  wire logic bus_wr = (ph_q == PH_WR) && !go && ba_hit_q;
  wire logic [15:0] bus_old = (ba_idx_q == R_STATUS) ? psw_q : regs_q[ba_idx_q];
  wire logic [15:0] bus_new = (bus_old & ~wmask_q) | (hwdata_in[15:0] & wmask_q);

  // writes wait while a micro-step runs so neither side loses its update
  assign hreadyout_out = ce_in && ((ph_q == PH_IDLE) || (ph_q == PH_RD_DONE)
    || ((ph_q == PH_WR) && !go));
  assign hresp_out = 1'b0;
  assign hrdata_out = hrdata_q;

  always_comb
  begin
    ph_d = ph_q;
    case (ph_q)
      PH_RD_WAIT: ph_d = PH_RD_DONE;
      PH_IDLE, PH_RD_DONE, PH_WR:
      begin
        if (hreadyout_out)
          ph_d = !ahb_go ? PH_IDLE : (hwrite_in ? PH_WR : PH_RD_WAIT);
      end
      default: ph_d = PH_IDLE;
    endcase
  end

  // register file next state
  always_comb
  begin
    for (int i = 0; i < NREG; i++)
      regs_d[i] = regs_q[i];
    if (go)
    begin
      if (is_mul)
      begin
        {regs_d[R_TMH], regs_d[R_TML]} = mul_w;
        if (step_op_in != OP_MULI)
        begin
          regs_d[R_ACC] = mul_w[15:0];
          if (step_word_in)
            regs_d[R_DATA] = mul_w[31:16];
        end
      end
      else if (is_div)
      begin
        {regs_d[R_TMH], regs_d[R_TML]} = {rem[15:0], quo[15:0]};
        if (step_word_in)
        begin
          regs_d[R_ACC] = quo[15:0];
          regs_d[R_DATA] = rem[15:0];
        end
        else
          regs_d[R_ACC] = {rem[7:0], quo[7:0]};
      end
      else if (is_sh)
        regs_d[R_TML] = sh_r;
      if (step_write_in && dst_ok && !is_div && !(is_mul && step_op_in != OP_MULI))
      begin
        if (step_word_in)
          regs_d[step_dst_sel_in] = wb;
        else if (step_dst_hi_in)
          regs_d[step_dst_sel_in][15:8] = wb[7:0];
        else
          regs_d[step_dst_sel_in][7:0] = wb[7:0];
      end
      case (step_ctl_in)
        CT_FLAGS_TO_AH: regs_d[R_ACC][15:8] = psw_q[7:0];
        CT_STR_STEP:
        begin
          regs_d[R_SRC] = psw_q[PSW_DIR] ? regs_q[R_SRC] - step_str
            : regs_q[R_SRC] + step_str;
          regs_d[R_DST] = psw_q[PSW_DIR] ? regs_q[R_DST] - step_str
            : regs_q[R_DST] + step_str;
        end
        CT_LOOP_DEC: regs_d[R_CNT] = regs_q[R_CNT] - ONE16;
        default: regs_d[R_CNT] = regs_d[R_CNT];
      endcase
    end
    else if (bus_wr && ba_idx_q != R_STATUS)
      regs_d[ba_idx_q] = bus_new;
  end

  // status word next state; control action applies after the flag update
  always_comb
  begin
    psw_d = psw_q;
    md_we_d = md_we_q;
    if (go)
    begin
      if (is_sh && sh_cnt != 5'h00)
      begin
        psw_d[PSW_CY] = sh_w[16];
        psw_d[PSW_V] = sh_left ? (sh_w[16] ^ sh_msb) : (sh_msb ^ sh_nxt);
        psw_d[PSW_S] = sh_msb;
        psw_d[PSW_Z] = step_word_in ? (sh_r == 16'h0000) : (sh_r[7:0] == 8'h00);
        psw_d[PSW_P] = ~^sh_r[7:0];
      end
      else if (is_mul)
      begin
        psw_d[PSW_CY] = !mul_fit;
        psw_d[PSW_V] = !mul_fit;
      end
      else if (is_div)
        psw_d[PSW_V] = 1'b0;
      else
        psw_d = (psw_q & ~alu_bus.fmask) | (alu_bus.flags & alu_bus.fmask);
      case (step_ctl_in)
        CT_INT_START:
        begin
          psw_d[PSW_IE] = 1'b0;
          psw_d[PSW_BRK] = 1'b0;
        end
        CT_FLAGS_FROM_AH: psw_d[7:0] = regs_q[R_ACC][15:8];
        CT_POP_STATUS, CT_RET_INT:
          psw_d = {md_we_q ? step_imm_in[PSW_MD] : psw_q[PSW_MD], step_imm_in[14:0]};
        CT_RET_EMU:
        begin
          psw_d = {1'b1, step_imm_in[14:0]};
          md_we_d = 1'b0;
        end
        CT_ENT_EMU:
        begin
          psw_d[PSW_MD] = 1'b0;
          md_we_d = 1'b1;
        end
        CT_NATIVE_CALL: psw_d[PSW_MD] = 1'b1;
        CT_SET_CY: psw_d[PSW_CY] = 1'b1;
        CT_CLR_CY: psw_d[PSW_CY] = 1'b0;
        CT_CMC: psw_d[PSW_CY] = ~psw_q[PSW_CY];
        CT_SET_DIR: psw_d[PSW_DIR] = 1'b1;
        CT_CLR_DIR: psw_d[PSW_DIR] = 1'b0;
        default: md_we_d = md_we_d;
      endcase
    end
    else if (bus_wr && ba_idx_q == R_STATUS)
      psw_d = bus_new;
    psw_d = (psw_d & ~PSW_FIXED) | PSW_ONES;
  end

  // state registers; all updates share the edge ending the step
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      for (int i = 0; i < NREG; i++)
        regs_q[i] <= REG_RST;
      psw_q <= PSW_RST;
      md_we_q <= MD_WE_RST;
    end
    else if (ce_in)
    begin
      regs_q <= regs_d;
      psw_q <= psw_d;
      md_we_q <= md_we_d;
    end
  end

  // bus slave phase, captured address and read data
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ph_q <= PH_IDLE;
      ba_idx_q <= 4'h0;
      ba_hit_q <= 1'b0;
      wmask_q <= 16'h0000;
      hrdata_q <= 32'h0000_0000;
    end
    else if (ce_in)
    begin
      ph_q <= ph_d;
      if (hreadyout_out && ahb_go)
      begin
        ba_idx_q <= haddr_in[5:2];
        ba_hit_q <= a_hit;
        wmask_q <= a_mask;
      end
      if (ph_q == PH_RD_WAIT)
        hrdata_q <= ba_hit_q ? {16'h0000, bus_old} : 32'h0000_0000;
    end
  end

  // exported state
  assign status_word_out = psw_q;
  assign src_addr_out = regs_q[R_SRC];
  assign dst_addr_out = regs_q[R_DST];
  assign io_data_out = regs_q[R_ACC];
  assign count_zero_out = (regs_q[R_CNT] == 16'h0000);
  assign native_mode_out = psw_q[PSW_MD];
  assign dir_flag_out = psw_q[PSW_DIR];
endmodule : caf_datapath
`default_nettype wire

/* File: core/caf_pkg.sv */
// package: constants and types shared by the execution datapath files
// assumes a single core clock domain; holds no logic
package caf_pkg;
  // register file slots; bus byte address is slot * 4
  localparam logic [3:0] R_ACC = 4'h0;
  localparam logic [3:0] R_BASE = 4'h1;
  localparam logic [3:0] R_CNT = 4'h2;
  localparam logic [3:0] R_DATA = 4'h3;
  localparam logic [3:0] R_STK = 4'h4;
  localparam logic [3:0] R_FRM = 4'h5;
  localparam logic [3:0] R_SRC = 4'h6;
  localparam logic [3:0] R_DST = 4'h7;
  localparam logic [3:0] R_TMH = 4'h8;
  localparam logic [3:0] R_TML = 4'h9;
  localparam logic [3:0] R_SCR = 4'hA;
  localparam logic [3:0] R_STATUS = 4'hB;
  localparam logic [3:0] R_IMM = 4'hF;
  localparam logic [3:0] NREG_SEL = 4'hB;
  localparam int NREG = 11;
  localparam logic [7:0] OFS_STATUS = 8'h2C;
  localparam logic [15:0] REG_RST = 16'h0000;
  // status word layout
  localparam int PSW_MD = 15;
  localparam int PSW_V = 11;
  localparam int PSW_DIR = 10;
  localparam int PSW_IE = 9;
  localparam int PSW_BRK = 8;
  localparam int PSW_S = 7;
  localparam int PSW_Z = 6;
  localparam int PSW_AC = 4;
  localparam int PSW_P = 2;
  localparam int PSW_CY = 0;
  localparam logic [15:0] PSW_ONES = 16'h7002;
  localparam logic [15:0] PSW_FIXED = 16'h702A;
  localparam logic [15:0] PSW_RST = 16'hF002;
  localparam logic MD_WE_RST = 1'b0;
  // flag groups touched by each operation class
  localparam logic [15:0] M_ARITH = 16'h08D5;
  localparam logic [15:0] M_INCDEC = 16'h08D4;
  localparam logic [15:0] M_LOGIC = 16'h08C5;
  localparam logic [15:0] M_ZERO = 16'h0040;
  localparam logic [15:0] ONE16 = 16'h0001;
  localparam logic [15:0] TWO16 = 16'h0002;
  localparam logic [15:0] WM_LO = 16'h00FF;
  localparam logic [15:0] WM_HI = 16'hFF00;
  localparam logic [15:0] WM_ALL = 16'hFFFF;

  typedef enum logic [20:0] {
    OP_PASS = 21'h0_0001, OP_ADD = 21'h0_0002, OP_ADC = 21'h0_0004,
    OP_SUB = 21'h0_0008, OP_SBB = 21'h0_0010, OP_INC = 21'h0_0020,
    OP_DEC = 21'h0_0040, OP_NOT = 21'h0_0080, OP_AND = 21'h0_0100,
    OP_OR = 21'h0_0200, OP_XOR = 21'h0_0400, OP_BTST = 21'h0_0800,
    OP_BSET = 21'h0_1000, OP_BCLR = 21'h0_2000, OP_BNOT = 21'h0_4000,
    OP_MULU = 21'h0_8000, OP_MULS = 21'h1_0000, OP_MULI = 21'h2_0000,
    OP_DIVU = 21'h4_0000, OP_DIVS = 21'h8_0000, OP_SHIFT = 21'h10_0000
  } caf_op_t;

  typedef enum logic [6:0] {
    SH_ROL = 7'h01, SH_ROR = 7'h02, SH_RCL = 7'h04, SH_RCR = 7'h08,
    SH_SHL = 7'h10, SH_SHR = 7'h20, SH_SAR = 7'h40
  } caf_shift_t;

  typedef enum logic [15:0] {
    CT_NONE = 16'h0001, CT_INT_START = 16'h0002, CT_FLAGS_FROM_AH = 16'h0004,
    CT_FLAGS_TO_AH = 16'h0008, CT_POP_STATUS = 16'h0010, CT_RET_INT = 16'h0020,
    CT_RET_EMU = 16'h0040, CT_ENT_EMU = 16'h0080, CT_NATIVE_CALL = 16'h0100,
    CT_SET_CY = 16'h0200, CT_CLR_CY = 16'h0400, CT_CMC = 16'h0800,
    CT_SET_DIR = 16'h1000, CT_CLR_DIR = 16'h2000, CT_STR_STEP = 16'h4000,
    CT_LOOP_DEC = 16'h8000
  } caf_ctl_t;

  typedef enum logic [3:0] {
    PH_IDLE = 4'h1, PH_RD_WAIT = 4'h2, PH_RD_DONE = 4'h4, PH_WR = 4'h8
  } caf_phase_t;
endpackage : caf_pkg

/* File: core/caf_alu_if.sv */
// interface: operands, result and flag image between datapath and alu
// assumes the datapath drives operands and the alu answers in the same cycle
`timescale 1ns/10ps
`default_nettype none
interface caf_alu_if;
  import caf_pkg::*;
  caf_op_t op;
  logic word;
  logic [15:0] a;
  logic [15:0] b;
  logic cy_in;
  logic [15:0] res;
  logic [15:0] flags;
  logic [15:0] fmask;
  modport dp (output op, word, a, b, cy_in, input res, flags, fmask);
  modport alu (input op, word, a, b, cy_in, output res, flags, fmask);
endinterface : caf_alu_if
`default_nettype wire

/* File: core/caf_alu.sv */
// alu: full adder plus logic unit, purely combinational
// assumes the datapath applies flags under fmask and keeps the rest
`timescale 1ns/10ps
`default_nettype none
module caf_alu
  import caf_pkg::*;
(
  caf_alu_if.alu bus // operands in, result and flags out
);
  // adder operand shaping; inc/dec reuse the same adder
  wire logic incdec = (bus.op == OP_INC) || (bus.op == OP_DEC);
  wire logic sub = (bus.op == OP_SUB) || (bus.op == OP_SBB) || (bus.op == OP_DEC);
  wire logic arith = (bus.op == OP_ADD) || (bus.op == OP_ADC) || (bus.op == OP_SUB)
    || (bus.op == OP_SBB);
  wire logic logic_op = (bus.op == OP_AND) || (bus.op == OP_OR) || (bus.op == OP_XOR);
  wire logic [15:0] add_b = incdec ? ONE16 : bus.b;
  wire logic [15:0] bi = sub ? ~add_b : add_b;
  wire logic cin = (bus.op == OP_ADC) ? bus.cy_in : (bus.op == OP_SBB) ? ~bus.cy_in : sub;
  wire logic [16:0] add17 = {1'b0, bus.a} + {1'b0, bi} + {16'h0000, cin};
  wire logic [15:0] sum = add17[15:0];
  // byte carry recovered from the bit-8 column so one adder serves both widths
  wire logic cout = bus.word ? add17[16] : (bus.a[8] ^ bi[8] ^ sum[8]);
  wire logic am = bus.word ? bus.a[15] : bus.a[7];
  wire logic bm = bus.word ? bi[15] : bi[7];
  wire logic sm = bus.word ? sum[15] : sum[7];
  wire logic ovf = (am == bm) && (sm != am);
  wire logic half = bus.a[4] ^ add_b[4] ^ sum[4];
  wire logic [15:0] bitm = ONE16 << (bus.word ? bus.b[3:0] : {1'b0, bus.b[2:0]});

  // result select
  always_comb
  begin
    case (bus.op)
      OP_ADD, OP_ADC, OP_SUB, OP_SBB, OP_INC, OP_DEC: bus.res = sum;
      OP_NOT: bus.res = ~bus.a;
      OP_AND: bus.res = bus.a & bus.b;
      OP_OR: bus.res = bus.a | bus.b;
      OP_XOR: bus.res = bus.a ^ bus.b;
      OP_BTST: bus.res = bus.a & bitm;
      OP_BSET: bus.res = bus.a | bitm;
      OP_BCLR: bus.res = bus.a & ~bitm;
      OP_BNOT: bus.res = bus.a ^ bitm;
      OP_PASS: bus.res = bus.b;
      default: bus.res = bus.a;
    endcase
  end

  // flag image and which flags it is allowed to change
  always_comb
  begin
    bus.flags = 16'h0000;
    bus.flags[PSW_CY] = arith && (cout ^ sub);
    bus.flags[PSW_V] = (arith || incdec) && ovf;
    bus.flags[PSW_AC] = half;
    bus.flags[PSW_S] = bus.word ? bus.res[15] : bus.res[7];
    bus.flags[PSW_Z] = bus.word ? (bus.res == 16'h0000) : (bus.res[7:0] == 8'h00);
    bus.flags[PSW_P] = ~^bus.res[7:0];
    if (arith)
      bus.fmask = M_ARITH;
    else if (incdec)
      bus.fmask = M_INCDEC;
    else if (logic_op)
      bus.fmask = M_LOGIC;
    else if (bus.op == OP_BTST)
      bus.fmask = M_ZERO;
    else
      bus.fmask = 16'h0000;
  end
endmodule : caf_alu
`default_nettype wire

/* File: bench/caf_datapath_properties.sv */
// checker: status word flag properties
// assumes a bind onto caf_datapath, single clock domain
`timescale 1ns/10ps
`default_nettype none
module caf_datapath_properties
  import caf_pkg::*;
(
  input wire logic sys_clk_in, // clock
  input wire logic rst_n_in, // reset
  input wire logic ce_in, // enable
  input wire logic step_valid_in, // step
  input wire caf_op_t step_op_in, // op
  input wire caf_ctl_t step_ctl_in, // control
  input wire logic [15:0] status_word_out, // status
  input wire logic native_mode_out, // mode
  input wire logic dir_flag_out // direction
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  // taken steps; a control action overrides alu flags, so alu checks exclude it
  wire go = step_valid_in && ce_in;
  wire alu = go && step_ctl_in == CT_NONE;
  wire [15:0] sw = status_word_out;
  reset_val_a: assert property ($rose(rst_n_in) |-> sw == PSW_RST)
    else $error("status not at reset value");
  fixed_bits_a: assert property ((sw & PSW_FIXED) == PSW_ONES)
    else $error("fixed status bits written");
  flag_pins_a: assert property (native_mode_out == sw[PSW_MD]
    && dir_flag_out == sw[PSW_DIR]) else $error("mode or direction pin");
  int_clear_a: assert property (go && step_ctl_in == CT_INT_START |=>
    sw[PSW_IE:PSW_BRK] == 2'b00) else $error("interrupt entry flags");
  carry_set_a: assert property (go && step_ctl_in == CT_SET_CY |=> sw[PSW_CY])
    else $error("carry not set");
  carry_inv_a: assert property (go && step_ctl_in == CT_CMC |=>
    sw[PSW_CY] != $past(sw[PSW_CY])) else $error("carry not inverted");
  incdec_keep_a: assert property (alu && step_op_in inside {OP_INC, OP_DEC} |=>
    $stable(sw[PSW_CY])) else $error("carry moved on inc or dec");
  logic_clear_a: assert property (alu && step_op_in inside {OP_AND, OP_OR, OP_XOR} |=>
    !sw[PSW_CY] && !sw[PSW_V]) else $error("logic left carry or overflow");
endmodule : caf_datapath_properties
bind caf_datapath caf_datapath_properties chk_u (.sys_clk_in, .rst_n_in, .ce_in, .step_valid_in,
  .step_op_in, .step_ctl_in, .status_word_out, .native_mode_out, .dir_flag_out);
`default_nettype wire

/* File: bench/caf_seq_model.sv */
// partner: micro-step source in the sequencer's place
// assumes run is called just after a rising edge
`timescale 1ns/10ps
`default_nettype none
module caf_seq_model
  import caf_pkg::*;
(
  input wire logic sys_clk_in, // clock
  output logic v_out, // step valid
  output caf_op_t op_out, // operation
  output caf_ctl_t ct_out, // control
  output logic w_out, // word
  output logic hi_out, // high byte
  output logic [3:0] a_out, // slot a and dst
  output logic [3:0] b_out, // slot b
  output logic [15:0] im_out, // immediate
  output logic wr_out // write back
);
  // quiet step until the first call
  initial
  begin
    {v_out, w_out, hi_out, wr_out} = 4'h0;
    op_out = OP_PASS;
    ct_out = CT_NONE;
    {a_out, b_out, im_out} = 24'h01_0000;
  end
  // one step for one edge; stale immediate inverted so it is never reused by luck
  task run(input caf_op_t op, input caf_ctl_t ct, input logic w, input logic h,
    input logic [3:0] a, input logic [15:0] im, input logic wr);
    begin
      v_out <= 1'b1;
      op_out <= op;
      ct_out <= ct;
      w_out <= w;
      hi_out <= h;
      a_out <= a;
      b_out <= a ^ 4'h1;
      im_out <= im;
      wr_out <= wr;
      @(posedge sys_clk_in);
      v_out <= 1'b0;
      ct_out <= CT_NONE;
      im_out <= ~im;
    end
  endtask : run
endmodule : caf_seq_model
`default_nettype wire

/* File: bench/cpu_alu_flags_datapath_test.sv */
// bench: random and corner runs of the datapath
// assumes caf_seq_model as sequencer, an AHB-Lite master here
`timescale 1ns/10ps
`default_nettype none
module cpu_alu_flags_datapath_test;
  import caf_pkg::*;
  logic sys_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic hsel_in = 1'b0;
  logic hwrite_in = 1'b0;
  logic [1:0] htrans_in = 2'h0;
  logic [31:0] haddr_in = 32'h0000_0000;
  logic [31:0] hwdata_in = 32'h0000_0000;
  logic [31:0] rq;
  wire logic [31:0] hrdata_out;
  wire logic hrdy, step_valid_in, step_word_in, hi, step_write_in;
  wire logic [3:0] step_a_sel_in, step_b_sel_in;
  wire logic [15:0] step_imm_in, sw, acc;
  caf_op_t step_op_in;
  caf_ctl_t step_ctl_in;
  int n_errors = 0;
  int total_checks = 0;
  int seed = 32'h09ad;
  // control steps: {imm code, expected bit, bit position}
  caf_ctl_t ct_t [16] = '{CT_POP_STATUS, CT_ENT_EMU, CT_POP_STATUS, CT_RET_EMU, CT_POP_STATUS,
    CT_SET_CY, CT_CMC, CT_CMC, CT_CLR_CY, CT_POP_STATUS, CT_INT_START, CT_POP_STATUS,
    CT_INT_START, CT_SET_DIR, CT_CLR_DIR, CT_RET_INT};
  logic [6:0] ex_t [16] = '{7'h1F, 7'h0F, 7'h3F, 7'h1F, 7'h1F, 7'h10, 7'h00, 7'h10, 7'h00,
    7'h59, 7'h49, 7'h58, 7'h48, 7'h1A, 7'h0A, 7'h59};
  always #5 sys_clk_in = ~sys_clk_in;
  caf_seq_model seq_u (.sys_clk_in, .v_out(step_valid_in), .op_out(step_op_in),
    .ct_out(step_ctl_in), .w_out(step_word_in), .hi_out(hi), .a_out(step_a_sel_in),
    .b_out(step_b_sel_in), .im_out(step_imm_in), .wr_out(step_write_in));
  caf_datapath dut_u (.sys_clk_in, .rst_n_in, .ce_in(1'b1), .hsel_in, .haddr_in, .htrans_in,
    .hwrite_in, .hsize_in(3'h2), .hwdata_in, .hready_in(hrdy), .hrdata_out, .hreadyout_out(hrdy),
    .hresp_out(), .step_valid_in, .step_op_in, .step_shift_in(SH_SHL), .step_ctl_in,
    .step_word_in, .step_use_cl_in(1'b0), .step_a_sel_in, .step_a_hi_in(hi), .step_b_sel_in,
    .step_b_hi_in(hi), .step_imm_in, .step_dst_sel_in(step_a_sel_in), .step_dst_hi_in(hi),
    .step_write_in, .status_word_out(sw), .src_addr_out(), .dst_addr_out(), .io_data_out(acc),
    .count_zero_out(), .native_mode_out(), .dir_flag_out());
  task stop_test;
    begin
      if (n_errors == 0 && total_checks > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask : stop_test
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    begin
      total_checks++;
      if (g !== e)
      begin
        $display("unexpected %s expected %h seen %h", n, e, g);
        n_errors++;
      end
    end
  endtask : chk
  // hready is read before the edge it is sampled at, so no race with the slave
  task rdy;
    int i;
    logic r;
    begin
      i = 0;
      do
      begin
        @(negedge sys_clk_in);
        rq = hrdata_out;
        r = hrdy;
        @(posedge sys_clk_in);
        i++;
      end
      while (r !== 1'b1 && i < 50);
      if (r !== 1'b1)
      begin
        n_errors++;
        stop_test();
      end
    end
  endtask : rdy
  task bus(input logic wr, input logic [7:0] ad, input logic [15:0] d);
    begin
      hsel_in <= 1'b1;
      htrans_in <= 2'h2;
      hwrite_in <= wr;
      haddr_in <= {24'h00_0000, ad};
      rdy();
      hsel_in <= 1'b0;
      htrans_in <= 2'h0;
      hwdata_in <= {16'h0000, d};
      rdy();
    end
  endtask : bus
  // expected {result, flags} of add, and, increment into the accumulator
  function automatic logic [31:0] expf(input int k, input logic [15:0] a, input logic [15:0] b,
    input logic w, input logic h);
    logic [16:0] s;
    logic [15:0] r;
    logic [15:0] f;
    logic [4:0] t;
    begin
      if (!w && h)
        {a, b} = {a[7:0], a[15:8], b[7:0], b[15:8]};
      if (k == 2)
        b = 16'h0001;
      s = w ? {1'b0, a} + {1'b0, b} : {9'h000, a[7:0]} + {9'h000, b[7:0]};
      t = {1'b0, a[3:0]} + {1'b0, b[3:0]};
      r = (k == 1) ? a & b : s[15:0];
      f = 16'h0000;
      f[PSW_CY] = (k != 1) && (w ? s[16] : s[8]);
      f[PSW_V] = (k != 1) && (w ? a[15] == b[15] && r[15] != a[15] : a[7] == b[7] && r[7] != a[7]);
      f[PSW_S] = w ? r[15] : r[7];
      f[PSW_Z] = w ? r == 16'h0000 : r[7:0] == 8'h00;
      f[PSW_AC] = t[4];
      f[PSW_P] = ~^r[7:0];
      r = w ? r : {a[15:8], r[7:0]};
      if (!w && h)
        r = {r[7:0], r[15:8]};
      return {r, f};
    end
  endfunction : expf
  // reset, status control table, then random arithmetic with corners first
  initial
  begin
    logic [31:0] r;
    logic [15:0] a, b, m;
    logic w;
    int i, k;
    repeat (10) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    @(negedge sys_clk_in);
    chk("status", PSW_RST, sw);
    @(posedge sys_clk_in);
    bus(1'b0, OFS_STATUS, 16'h0000);
    chk("status_rd", {16'h0000, PSW_RST}, rq);
    for (i = 0; i < 16; i++)
    begin
      m = ex_t[i][6] ? 16'h0300 : {ex_t[i][5], 15'h0000};
      seq_u.run(OP_PASS, ct_t[i], 1'b1, 1'b0, R_ACC, m, 1'b0);
      @(negedge sys_clk_in);
      chk("flag", ex_t[i][4], sw[ex_t[i][3:0]]);
      @(posedge sys_clk_in);
    end
    for (i = 0; i < 60; i++)
    begin
      r = $random(seed);
      {b, a} = r;
      if (i < 2)
        {b, a} = {16'h0001, 16'hFFFF >> i};
      w = (i < 2) || r[9];
      k = (i < 2) ? 0 : i % 3;
      m = (k == 0) ? M_ARITH : (k == 1) ? M_LOGIC : M_INCDEC;
      bus(1'b1, 8'h00, a);
      bus(1'b1, 8'h04, b);
      bus(1'b0, 8'h04, 16'h0000);
      chk("base_rd", {16'h0000, b}, rq);
      seq_u.run(k[1] ? OP_INC : k[0] ? OP_AND : OP_ADD, CT_NONE, w, r[25], R_ACC, 16'h0000, 1'b1);
      r = expf(k, a, b, w, r[25]);
      @(negedge sys_clk_in);
      chk("flags", r[15:0] & m, sw & m);
      chk("result", r[31:16], acc);
      @(posedge sys_clk_in);
    end
    stop_test();
  end
endmodule : cpu_alu_flags_datapath_test
`default_nettype wire
